// File: shwc_pkg.sv
// Purpose: shared constants and types for the standby halt / wake-up controller
// Assumes: one free-running oscillator clock drives the controller itself
// Notes: warm-up counts are in oscillator periods
// ============================================================
// package
// ============================================================
package shwc_pkg;
  // register byte offsets
  localparam logic [7:0] SHWC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SHWC_STAT_OFS = 8'h04;
  // control field positions
  localparam int SHWC_WSEL_LSB = 0;
  localparam int SHWC_WSEL_MSB = 1;
  localparam int SHWC_MODE_BIT = 2;
  localparam int SHWC_SEL_BIT = 3;
  localparam int SHWC_EN_BIT = 4;
  // control reset: warm-up 2^14, oscillator-only halt, both drive bits low
  localparam logic [4:0] SHWC_CTRL_RST = 5'h02;
  // warm-up select codes
  localparam logic [1:0] SHWC_WSEL_RSV = 2'h0;
  localparam logic [1:0] SHWC_WSEL_8 = 2'h1;
  localparam logic [1:0] SHWC_WSEL_14 = 2'h2;
  localparam logic [1:0] SHWC_WSEL_16 = 2'h3;
  // warm-up lengths in oscillator periods
  localparam logic [16:0] SHWC_WUP_8 = 17'h00100;
  localparam logic [16:0] SHWC_WUP_14 = 17'h04000;
  localparam logic [16:0] SHWC_WUP_16 = 17'h10000;
  // controller states
  typedef enum logic [1:0] {
    SHWC_RUN = 2'b00,
    SHWC_IDLE = 2'b01,
    SHWC_STOP = 2'b10,
    SHWC_WARM = 2'b11
  } shwc_state_t;
endpackage

// File: shwc_top.sv
// Purpose: halt controller for the oscillator-only halt and the full-stop halt
// Assumes: sys_clk is the free-running oscillator; system clock gating is done outside from sys_clk_en
// Notes: wake pins are asynchronous and pass a two-flop synchroniser first
// Behaviour
// R1: oscillator-only halt keeps oscillator, stops system clock
// R2: oscillator-only halt pins follow drive bits
// R3: wake requests sampled without the system clock
// R4: halt exit happens synchronous to system clock
// R5: full stop halts everything, oscillator included
// R6: full stop pins follow drive bits
// R7: clock withheld until warm-up after full stop
// R8: warm-up codes give 2^8, 2^14, 2^16
// R9: wake input buffers zero and one stay on
// R10: pin condition table per mode and bits
// R11: full-stop wake completes only after warm-up
// R12: warm-up code 00 reserved, falls back shortest
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module shwc_top
  import shwc_pkg::*;
#(
  parameter logic [16:0] WUP_CNT_14 = SHWC_WUP_14, // shorten for simulation
  parameter logic [16:0] WUP_CNT_16 = SHWC_WUP_16  // shorten for simulation
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic halt_req,
  input wire logic [3:0] ext_irq_pin,
  output logic sys_clk_en,
  output logic osc_run,
  output logic halted,
  output logic halt_release,
  output logic pin_cond_b,
  output logic [1:0] irq_buf_en
);

  // ============================================================
  // decode helpers
  // ============================================================
  // warm-up length for a select code
  function automatic logic [16:0] wup_len(input logic [1:0] code);
    case (code)
      SHWC_WSEL_8: wup_len = SHWC_WUP_8; // R8
      SHWC_WSEL_14: wup_len = WUP_CNT_14; // R8
      SHWC_WSEL_16: wup_len = WUP_CNT_16; // R8
      default: wup_len = SHWC_WUP_8; // R12
    endcase
  endfunction

  // pin condition: 1 = condition B, 0 = condition A
  function automatic logic cond_b(input logic stop, input logic en, input logic sel);
    if (en) begin
      cond_b = 1'b1; // R10
    end else if (stop) begin
      cond_b = 1'b0; // R10
    end else begin
      cond_b = ~sel; // R10
    end
  endfunction

  // ============================================================
  // wake pin synchroniser
  // ============================================================
  logic [3:0] irq_s1_q; // first stage, read only by second
  logic [3:0] irq_s2_q; // synchronised wake levels
  logic wake; // any wake pin asserted

  // sampled on the oscillator, never on the gated system clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_s1_q <= 4'h0;
      irq_s2_q <= 4'h0;
    end else begin
      irq_s1_q <= ext_irq_pin; // R3
      irq_s2_q <= irq_s1_q; // R3
    end
  end

  assign wake = |irq_s2_q;

  // ============================================================
  // register port
  // ============================================================
  logic [4:0] ctrl_q; // standby_control_reg
  logic [4:0] ctrl_d;
  logic [7:0] rdata_q; // read answer, stands one cycle
  logic [7:0] rdata_d;
  logic [1:0] warmup_length_select; // field of standby_control_reg
  logic stop_sel; // 1 selects full stop, 0 oscillator_only_halt
  logic drive_sel; // pin drive select
  logic drive_en; // halt pin drive enable

  assign warmup_length_select = ctrl_q[SHWC_WSEL_MSB:SHWC_WSEL_LSB];
  assign stop_sel = ctrl_q[SHWC_MODE_BIT];
  assign drive_sel = ctrl_q[SHWC_SEL_BIT];
  assign drive_en = ctrl_q[SHWC_EN_BIT];

  shwc_state_t state_q;
  shwc_state_t state_d;
  logic [16:0] wcnt_q; // warm-up periods left minus one
  logic [16:0] wcnt_d;

  // write decode and read mux
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = 8'h00;
    if (reg_wr && reg_addr == SHWC_CTRL_OFS) begin
      ctrl_d = reg_wdata[4:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        SHWC_CTRL_OFS: rdata_d = {3'h0, ctrl_q};
        SHWC_STAT_OFS: rdata_d = {5'h00, (state_q == SHWC_WARM), state_q};
        default: rdata_d = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  // register storage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= SHWC_CTRL_RST;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ============================================================
  // halt state machine
  // ============================================================
  logic clk_en_q; // system clock gate enable
  logic clk_en_d;
  logic osc_q; // oscillator run request
  logic osc_d;
  logic rel_q; // one-cycle halt release to the core
  logic rel_d;
  logic condb_q; // pin condition while halted
  logic condb_d;
  logic [1:0] ibuf_q; // input buffer enables for wake pins zero and one
  logic [1:0] ibuf_d;
  logic halted_q; // own flop so the halted pin carries no inverter glitch
  logic halted_d;

  // next state; reset ends any halt through the synchronous clear below
  always_comb begin
    state_d = state_q;
    wcnt_d = wcnt_q;
    rel_d = 1'b0;
    case (state_q)
      SHWC_RUN: begin
        if (halt_req) begin
          state_d = stop_sel ? SHWC_STOP : SHWC_IDLE;
        end
      end
      SHWC_IDLE: begin
        // release lands on a clock edge, so the core restarts cleanly
        if (wake) begin
          state_d = SHWC_RUN; // R4
          rel_d = 1'b1; // R4
        end
      end
      SHWC_STOP: begin
        if (wake) begin
          state_d = SHWC_WARM; // R11
          wcnt_d = wup_len(warmup_length_select) - 17'h00001; // R8
        end
      end
      SHWC_WARM: begin
        // oscillator is settling; no release until the count runs out
        if (wcnt_q == 17'h00000) begin
          state_d = SHWC_RUN; // R7
          rel_d = 1'b1; // R11
        end else begin
          wcnt_d = wcnt_q - 17'h00001; // R7
        end
      end
      default: state_d = SHWC_RUN;
    endcase
  end

  // outputs derived from the next state so they change with it
  always_comb begin
    clk_en_d = (state_d == SHWC_RUN); // R1 R5 R7
    osc_d = (state_d != SHWC_STOP); // R1 R5
    condb_d = cond_b(state_d != SHWC_IDLE, drive_en, drive_sel); // R2 R6 R10
    ibuf_d = 2'h3; // R9
    halted_d = ~clk_en_d; // R1 R5
  end

  // state and output registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= SHWC_RUN;
      wcnt_q <= 17'h00000;
      rel_q <= 1'b0;
      clk_en_q <= 1'b1;
      osc_q <= 1'b1;
      condb_q <= 1'b0;
      ibuf_q <= 2'h3;
      halted_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wcnt_q <= wcnt_d;
      rel_q <= rel_d;
      clk_en_q <= clk_en_d;
      osc_q <= osc_d;
      condb_q <= condb_d;
      ibuf_q <= ibuf_d;
      halted_q <= halted_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign sys_clk_en = clk_en_q;
  assign osc_run = osc_q;
  assign halted = halted_q;
  assign halt_release = rel_q;
  assign pin_cond_b = condb_q;
  assign irq_buf_en = ibuf_q;

  // ============================================================
  // assertions
  // ============================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // helper: warm-up cycles seen and length latched at entry
  logic [16:0] chk_cnt_q;
  logic [16:0] chk_len_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chk_cnt_q <= 17'h00000;
      chk_len_q <= 17'h00000;
    end else begin
      chk_cnt_q <= (state_q == SHWC_WARM) ? chk_cnt_q + 17'h00001 : 17'h00000;
      if (state_q == SHWC_STOP && wake) begin
        chk_len_q <= wup_len(warmup_length_select);
      end
    end
  end

  property p_idle_clocks;
    state_q == SHWC_IDLE |-> osc_run && !sys_clk_en;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle clocks wrong"); // R1

  property p_idle_pins;
    state_q == SHWC_IDLE && $stable(ctrl_q) |-> pin_cond_b == (drive_en | ~drive_sel);
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle pin condition wrong"); // R2

  property p_wake_idle;
    state_q == SHWC_IDLE && wake |=> state_q == SHWC_RUN && halt_release && sys_clk_en;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("idle wake missed"); // R3

  property p_release_sync;
    $rose(sys_clk_en) |-> halt_release && state_q == SHWC_RUN;
  endproperty
  a_release_sync: assert property (p_release_sync) else $error("clock resumed without release"); // R4

  property p_stop_clocks;
    state_q == SHWC_STOP |-> !osc_run && !sys_clk_en;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("stop clocks wrong"); // R5

  property p_stop_pins;
    state_q == SHWC_STOP && $stable(ctrl_q) |-> pin_cond_b == drive_en;
  endproperty
  a_stop_pins: assert property (p_stop_pins) else $error("stop pin condition wrong"); // R6 R10

  property p_warm_hold;
    state_q == SHWC_WARM |-> !sys_clk_en && osc_run && !halt_release;
  endproperty
  a_warm_hold: assert property (p_warm_hold) else $error("clock during warm-up"); // R7

  property p_warm_len;
    state_q == SHWC_WARM && state_d == SHWC_RUN |-> chk_cnt_q + 17'h00001 == chk_len_q;
  endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong"); // R8

  property p_ibuf;
    irq_buf_en == 2'h3;
  endproperty
  a_ibuf: assert property (p_ibuf) else $error("wake input buffer off"); // R9

  property p_stop_wake;
    state_q == SHWC_STOP && wake |=> state_q == SHWC_WARM ##1 !halt_release;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake skipped warm-up"); // R11

  property p_rsv_code;
    state_q == SHWC_STOP && wake && warmup_length_select == SHWC_WSEL_RSV |=> wcnt_q == 17'h000FF;
  endproperty
  a_rsv_code: assert property (p_rsv_code) else $error("reserved code length wrong"); // R12

  c_idle_wake: cover property (state_q == SHWC_IDLE ##1 state_q == SHWC_RUN);
  c_stop_wake: cover property (state_q == SHWC_WARM ##1 state_q == SHWC_RUN);
  c_enter_stop: cover property (state_q == SHWC_RUN ##1 state_q == SHWC_STOP);

endmodule // shwc_top

// File: shwc_irq_model.sv
// Purpose: wake source model for the external interrupt pins
// Assumes: wake is level sensed, so a raised pin is held until the halt ends
// Notes: a pulse shorter than the synchroniser could be lost, hence the hold
`timescale 1ns/1ps
// ============================================================
// wake pin model
// ============================================================
module shwc_irq_model (
  input wire logic sys_clk,
  input wire logic [3:0] raise,
  input wire logic halt_release,
  output logic [3:0] ext_irq_pin
);
  // pins idle low, latch a raise, drop once the halt has ended
  always @(posedge sys_clk) begin
    if (halt_release === 1'b1) begin
      ext_irq_pin <= 4'h0;
    end else begin
      ext_irq_pin <= (ext_irq_pin === 4'hX) ? raise : (ext_irq_pin | raise);
    end
  end
endmodule // shwc_irq_model

// File: tb_top.sv
// Purpose: self-checking bench for the standby halt controller
// Assumes: warm-up parameters shortened to 32 and 64
// Notes: latency counts include one edge inside the wake model
`timescale 1ns/1ps
module tb_top;
  import shwc_pkg::*;
  // ============================================================
  // signals
  // ============================================================
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt_req = 1'b0;
  logic [3:0] raise = 4'h0;
  logic [7:0] reg_rdata;
  logic [3:0] ext_irq_pin;
  logic sys_clk_en, osc_run, halted, halt_release, pin_cond_b;
  logic [1:0] irq_buf_en;
  logic [6:0] outs; // all status outputs in one word
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  assign outs = {sys_clk_en, osc_run, halted, halt_release, pin_cond_b, irq_buf_en};
  always #12.5 sys_clk = ~sys_clk;
  shwc_top #(.WUP_CNT_14(17'h00020), .WUP_CNT_16(17'h00040)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_req(halt_req), .ext_irq_pin(ext_irq_pin), .sys_clk_en(sys_clk_en), .osc_run(osc_run),
    .halted(halted), .halt_release(halt_release), .pin_cond_b(pin_cond_b), .irq_buf_en(irq_buf_en));
  shwc_irq_model irq_src (.sys_clk(sys_clk), .raise(raise), .halt_release(halt_release),
    .ext_irq_pin(ext_irq_pin));
  // ============================================================
  // tasks
  // ============================================================
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // bus tasks start at a rising edge and end at one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 cmp({9'h0, reg_rdata}, {9'h0, exp});
    @(posedge sys_clk);
  endtask
  // halt with a control value, wake on a pin, measure edges to release
  task automatic halt_wake(input logic [7:0] ctrl, input logic pcb, input logic [3:0] pin,
                           input logic [16:0] lat);
    int n;
    logic held;
    n = 0;
    held = 1'b1;
    wr(SHWC_CTRL_OFS, ctrl);
    halt_req <= 1'b1;
    @(posedge sys_clk);
    halt_req <= 1'b0;
    #1 cmp({10'h0, outs}, {10'h0, 1'b0, ~ctrl[2], 1'b1, 1'b0, pcb, 2'h3});
    @(posedge sys_clk);
    rd(SHWC_STAT_OFS, {6'h0, ctrl[2] ? 2'h2 : 2'h1});
    raise <= pin;
    while (halt_release !== 1'b1 && n < 70000) begin
      @(posedge sys_clk);
      raise <= 4'h0;
      #1 n++;
      if (halt_release !== 1'b1) held &= (sys_clk_en === 1'b0) && (irq_buf_en === 2'h3);
    end
    cmp({16'h0, held}, 17'h1);
    cmp(n[16:0], lat);
    // running again: clock and oscillator on, release up, pins on the run formula
    cmp({10'h0, outs}, {10'h0, 4'hD, ctrl[4], 2'h3});
    @(posedge sys_clk);
    #1 cmp({16'h0, halt_release}, 17'h0);
    // step back onto an edge so the next task drives right after it
    @(posedge sys_clk);
  endtask
  // reset values of the status outputs, checked while reset is still held
  task automatic check_reset();
    repeat (9) @(posedge sys_clk);
    #1 cmp({10'h0, outs}, 17'h00063);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
  endtask
  // control reset value, refused writes and unmapped reads
  task automatic reg_access();
    rd(SHWC_CTRL_OFS, {3'h0, SHWC_CTRL_RST});
    wr(8'h44, 8'h1F);
    rd(8'h44, 8'h00);
    wr(SHWC_STAT_OFS, 8'h1F);
    rd(SHWC_CTRL_OFS, {3'h0, SHWC_CTRL_RST});
  endtask
  // a second reset in the middle of a full stop brings everything back to run
  task automatic reset_in_halt();
    wr(SHWC_CTRL_OFS, 8'h05);
    halt_req <= 1'b1;
    @(posedge sys_clk);
    halt_req <= 1'b0;
    #1 cmp({16'h0, halted}, 17'h1);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    #1 cmp({10'h0, outs}, 17'h00063);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(SHWC_STAT_OFS, 8'h00);
    rd(SHWC_CTRL_OFS, {3'h0, SHWC_CTRL_RST});
  endtask
  // ============================================================
  // sequence
  // ============================================================
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    check_reset();
    reg_access();
    halt_wake(8'h01, 1'b1, 4'h1, 17'd4);
    halt_wake(8'h09, 1'b0, 4'h2, 17'd4);
    halt_wake(8'h11, 1'b1, 4'h4, 17'd4);
    halt_wake(8'h19, 1'b1, 4'h8, 17'd4);
    halt_wake(8'h05, 1'b0, 4'h1, 17'd260);
    halt_wake(8'h0E, 1'b0, 4'h2, 17'd36);
    halt_wake(8'h17, 1'b1, 4'h4, 17'd68);
    halt_wake(8'h1C, 1'b1, 4'h8, 17'd260);
    reset_in_halt();
    rd(SHWC_STAT_OFS, 8'h00);
    stop_test();
  end
endmodule // tb_top
